// File: logic/sp_pkg.sv
// Package of constants and types for the serial port datapath
package sp_pkg;
    localparam logic [7:0] SP_ADDR_TIMER = 8'h14;
    localparam logic [7:0] SP_ADDR_RECEIVE_HOLDING_BUFFER = 8'h16;
    localparam logic [7:0] SP_ADDR_TRANSMIT_HOLDING_BUFFER = 8'h17;
    localparam int SP_DATA_W = 8;
    localparam int SP_FIFO_DEPTH = 16;
    localparam logic [1:0] SP_PRESCALE_LAST = 2'h3;
    localparam logic [3:0] SP_MIN_LEN = 4'h5;
    localparam logic [2:0] SP_VOTE_A = 3'h3;
    localparam logic [2:0] SP_VOTE_B = 3'h4;
    localparam logic [2:0] SP_VOTE_C = 3'h5;
    localparam logic [2:0] SP_PHASE_LAST = 3'h7;
    localparam logic [7:0] SP_TIMER_RESET = 8'h00;

    typedef enum logic [1:0] {
        SP_ASYNC = 2'b00,
        SP_ISO = 2'b01,
        SP_SIO = 2'b10
    } sp_mode_t;

    typedef enum logic [1:0] {
        SP_RX_IDLE = 2'b00,
        SP_RX_HUNT = 2'b01,
        SP_RX_BITS = 2'b10
    } sp_rx_state_t;

    typedef enum logic [2:0] {
        SP_TX_IDLE = 3'b000,
        SP_TX_START = 3'b001,
        SP_TX_DATA = 3'b010,
        SP_TX_PAR = 3'b011,
        SP_TX_STOP = 3'b100
    } sp_tx_state_t;

    typedef struct packed {
        sp_mode_t mode;
        logic [1:0] len_code;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic clk_internal;
    } sp_cfg_t;

    typedef struct packed {
        logic transmit_room_flag;
        logic receive_full_flag;
        logic transmitter_idle_flag;
        logic parity_fault_flag;
        logic overrun_flag;
        logic framing_fault_flag;
    } sp_status_t;
endpackage

// File: logic/sp_fifo.sv
// Parameterised FIFO for the transmit data path
`timescale 1ns/100ps
`default_nettype none
module sp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    assign o_out_valid = wr_ptr != rd_ptr;
    assign o_in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign o_out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_clk_sys)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= i_in_data;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (i_flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule // sp_fifo
`default_nettype wire

// File: logic/sp_serial_port.sv
// Serial port datapath: baud timer, receiver, transmitter and flags
`timescale 1ns/100ps
`default_nettype none
module sp_serial_port (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [7:0] i_pf_addr,
    input wire logic i_pf_wr,
    input wire logic i_pf_rd,
    input wire logic [7:0] i_pf_wdata,
    output logic [7:0] o_pf_rdata,
    input wire sp_pkg::sp_cfg_t i_cfg,
    input wire logic i_ctl_wr,
    input wire logic i_receive_enable_bit,
    input wire logic i_transmit_enable_bit,
    input wire logic i_port_soft_reset,
    input wire logic i_error_clear_bit,
    input wire logic i_serial_irq_clear,
    input wire logic i_irq_ack,
    input wire logic i_rxd,
    input wire logic i_sclk,
    output logic o_sclk,
    output logic o_sclk_oe_n,
    output logic o_sclk_level,
    output logic o_txd,
    output logic o_serial_irq_flag,
    output sp_pkg::sp_status_t o_status
);
    import sp_pkg::*;

    function automatic logic [7:0] right_align(input logic [7:0] sh, input logic [1:0] code);
        right_align = sh >> (2'h3 - code);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers and baud timer
    // ------------------------------------------------------------
    logic [2:0] sclk_sync;
    logic [2:0] rxd_sync;
    logic ext_lvl;
    logic rxd_lvl;
    logic [1:0] pre;
    logic [7:0] reload;
    logic [7:0] count;
    logic sclk_int;
    logic gate_en;
    logic s_prev;
    logic rx_en;
    logic tx_en;
    wire ureset = i_port_soft_reset;
    wire is_sio = i_cfg.mode == SP_SIO;
    wire [3:0] len = SP_MIN_LEN + {2'b00, i_cfg.len_code};
    wire pre_tick = pre == SP_PRESCALE_LAST;
    wire timer_zero = pre_tick && count == 8'h00;
    wire wr_timer = i_pf_wr && i_pf_addr == SP_ADDR_TIMER;
    wire wr_transmit_holding_buffer = i_pf_wr && i_pf_addr == SP_ADDR_TRANSMIT_HOLDING_BUFFER;
    wire rd_receive_holding_buffer = i_pf_rd && i_pf_addr == SP_ADDR_RECEIVE_HOLDING_BUFFER;
    // Serial I/O gates the clock so the pin rests high between frames
    wire pin_val = (is_sio && !gate_en) ? 1'b1 : sclk_int;
    wire s_lvl = i_cfg.clk_internal ? pin_val : ext_lvl;
    wire s_rise = !ureset && s_lvl && !s_prev;
    wire s_fall = !ureset && !s_lvl && s_prev;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sclk_sync <= 3'h7;
            rxd_sync <= 3'h7;
            ext_lvl <= 1'b1;
            rxd_lvl <= 1'b1;
            pre <= 2'h0;
            reload <= SP_TIMER_RESET;
            count <= SP_TIMER_RESET;
            sclk_int <= 1'b1;
            s_prev <= 1'b1;
        end
        else
        begin
            sclk_sync <= {sclk_sync[1:0], i_sclk};
            rxd_sync <= {rxd_sync[1:0], i_rxd};
            // A change counts only once stages two and three agree
            if (sclk_sync[1] == sclk_sync[2])
                ext_lvl <= sclk_sync[2];
            if (rxd_sync[1] == rxd_sync[2])
                rxd_lvl <= rxd_sync[2];
            pre <= pre + 2'h1;
            if (wr_timer)
                reload <= i_pf_wdata;
            if (pre_tick)
                count <= (count == 8'h00) ? reload : count - 8'h01;
            if (timer_zero)
                sclk_int <= !sclk_int;
            s_prev <= s_lvl;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    sp_rx_state_t rx_state;
    logic [2:0] rph;
    logic [1:0] votes;
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic rpar;
    logic rx_last;
    logic rx_done;
    logic rx_fe;
    logic rx_pe;
    logic [7:0] rx_buf;
    wire majority = (votes[0] & votes[1]) | (votes[0] & rxd_lvl) | (votes[1] & rxd_lvl);
    wire async_mode = i_cfg.mode == SP_ASYNC;
    wire rbit_ev = s_rise && rx_state == SP_RX_BITS && (!async_mode || rph == SP_VOTE_C);
    wire rbit = async_mode ? majority : rxd_lvl;
    wire rx_is_data = ridx < len;
    wire rx_sio_end = is_sio && ridx == len - 4'h1;
    // In communication modes the shifter keeps assembling with the receiver disabled
    wire rx_load = rx_done && (is_sio || rx_en);

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rx_state <= SP_RX_IDLE;
            rph <= 3'h0;
            votes <= 2'h0;
            ridx <= 4'h0;
            rsh <= 8'h00;
            rpar <= 1'b0;
            rx_last <= 1'b1;
            rx_done <= 1'b0;
            rx_fe <= 1'b0;
            rx_pe <= 1'b0;
        end
        else if (ureset)
        begin
            rx_state <= SP_RX_IDLE;
            rx_last <= 1'b1;
            rx_done <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (s_rise)
            begin
                rx_last <= rxd_lvl;
                rph <= rph + 3'h1;
                if (rph == SP_VOTE_A)
                    votes[0] <= rxd_lvl;
                if (rph == SP_VOTE_B)
                    votes[1] <= rxd_lvl;
            end
            unique case (rx_state)
                SP_RX_IDLE:
                begin
                    ridx <= 4'h0;
                    rpar <= 1'b0;
                    // A stale parity result must not reach a later frame sent without parity
                    rx_pe <= 1'b0;
                    // Enable drops one edge after done, so done alone blocks a second frame
                    if (is_sio && rx_en && !rx_done)
                        rx_state <= SP_RX_BITS;
                    else if (!is_sio && s_rise && rx_last && !rxd_lvl)
                    begin
                        rph <= 3'h1;
                        rx_state <= async_mode ? SP_RX_HUNT : SP_RX_BITS;
                    end
                end
                SP_RX_HUNT:
                    if (s_rise && rph == SP_VOTE_C)
                        rx_state <= majority ? SP_RX_IDLE : SP_RX_BITS;
                SP_RX_BITS:
                    if (rbit_ev)
                    begin
                        ridx <= ridx + 4'h1;
                        if (rx_is_data)
                        begin
                            rsh <= {rbit, rsh[7:1]};
                            rpar <= rpar ^ rbit;
                        end
                        else if (i_cfg.parity_en && ridx == len)
                            rx_pe <= rpar ^ rbit ^ i_cfg.parity_odd;
                        else
                        begin
                            rx_fe <= !rbit;
                            rx_done <= 1'b1;
                            rx_state <= SP_RX_IDLE;
                        end
                        if (rx_sio_end)
                        begin
                            rx_pe <= 1'b0;
                            rx_fe <= 1'b0;
                            rx_done <= 1'b1;
                            rx_state <= SP_RX_IDLE;
                        end
                    end
                default:
                    rx_state <= SP_RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmitter with FIFO holding buffer
    // ------------------------------------------------------------
    sp_tx_state_t tx_state;
    logic [2:0] tph;
    logic [3:0] tidx;
    logic [1:0] sidx;
    logic [7:0] tsh;
    logic tpar;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    wire tx_load = tx_state == SP_TX_IDLE && tx_en && fifo_valid && !ureset;
    wire tstep = s_fall && (!async_mode || tph == SP_PHASE_LAST);
    wire sio_tx_end = is_sio && s_rise && tidx == len;

    sp_fifo #(.WIDTH(SP_DATA_W), .DEPTH(SP_FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_flush(ureset),
        .i_in_valid(wr_transmit_holding_buffer),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_pf_wdata),
        .o_out_valid(fifo_valid),
        .i_out_ready(tx_load),
        .o_out_data(fifo_data)
    );

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tx_state <= SP_TX_IDLE;
            tph <= 3'h0;
            tidx <= 4'h0;
            sidx <= 2'h0;
            tsh <= 8'h00;
            tpar <= 1'b0;
            o_txd <= 1'b1;
        end
        else if (ureset)
        begin
            tx_state <= SP_TX_IDLE;
            o_txd <= 1'b1;
        end
        else
        begin
            if (s_fall)
                tph <= tph + 3'h1;
            unique case (tx_state)
                SP_TX_IDLE:
                    if (tx_load)
                    begin
                        tsh <= fifo_data;
                        tidx <= 4'h0;
                        tpar <= 1'b0;
                        tx_state <= is_sio ? SP_TX_DATA : SP_TX_START;
                    end
                SP_TX_START:
                    if (s_fall)
                    begin
                        o_txd <= 1'b0;
                        tph <= 3'h0;
                        tx_state <= SP_TX_DATA;
                    end
                SP_TX_DATA:
                    if (sio_tx_end)
                        tx_state <= SP_TX_IDLE;
                    else if (tstep && tidx != len)
                    begin
                        o_txd <= tsh[0];
                        tpar <= tpar ^ tsh[0];
                        tsh <= tsh >> 1;
                        tidx <= tidx + 4'h1;
                    end
                    else if (tstep && !is_sio)
                    begin
                        o_txd <= i_cfg.parity_en ? tpar ^ i_cfg.parity_odd : 1'b1;
                        sidx <= 2'h1;
                        tx_state <= i_cfg.parity_en ? SP_TX_PAR : SP_TX_STOP;
                    end
                SP_TX_PAR:
                    if (tstep)
                    begin
                        o_txd <= 1'b1;
                        tx_state <= SP_TX_STOP;
                    end
                SP_TX_STOP:
                    if (tstep)
                    begin
                        sidx <= sidx + 2'h1;
                        if (sidx == (i_cfg.two_stop ? 2'h2 : 2'h1))
                            tx_state <= SP_TX_IDLE;
                    end
                default:
                    tx_state <= SP_TX_IDLE;
            endcase
            if (is_sio && tstep && tidx == len)
                o_txd <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Enables, flags and register answers
    // ------------------------------------------------------------
    wire sio_active = is_sio && (tx_state != SP_TX_IDLE || rx_state == SP_RX_BITS);
    wire irq_set = rx_load || tx_load;
    wire error_clear_any = i_error_clear_bit || ureset;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rx_en <= 1'b0;
            tx_en <= 1'b0;
            gate_en <= 1'b0;
            rx_buf <= 8'h00;
            o_pf_rdata <= 8'h00;
            o_sclk <= 1'b1;
            o_sclk_oe_n <= 1'b1;
            o_sclk_level <= 1'b1;
            o_serial_irq_flag <= 1'b0;
            o_status <= 6'b111000;
        end
        else
        begin
            if (i_ctl_wr)
            begin
                rx_en <= i_receive_enable_bit;
                tx_en <= i_transmit_enable_bit;
            end
            if (ureset)
                rx_en <= 1'b0;
            else if (rx_done && is_sio)
                rx_en <= 1'b0;
            if (sclk_int)
                gate_en <= sio_active;
            o_sclk <= pin_val;
            o_sclk_oe_n <= ureset || !i_cfg.clk_internal;
            o_sclk_level <= s_lvl;
            if (i_pf_rd)
                o_pf_rdata <= (i_pf_addr == SP_ADDR_TIMER) ? count
                    : (i_pf_addr == SP_ADDR_RECEIVE_HOLDING_BUFFER) ? rx_buf : 8'h00;
            if (rx_load)
                rx_buf <= right_align(rsh, i_cfg.len_code);
            if (i_serial_irq_clear || i_irq_ack || ureset)
                o_serial_irq_flag <= 1'b0;
            if (irq_set && !ureset)
                o_serial_irq_flag <= 1'b1;
            o_status.transmit_room_flag <= ureset || fifo_in_ready;
            o_status.transmitter_idle_flag <= ureset || (!fifo_valid && !wr_transmit_holding_buffer
                && tx_state == SP_TX_IDLE && !tx_load);
            if (rd_receive_holding_buffer || ureset)
                o_status.receive_full_flag <= ureset;
            if (error_clear_any)
            begin
                o_status.parity_fault_flag <= 1'b0;
                o_status.overrun_flag <= 1'b0;
                o_status.framing_fault_flag <= 1'b0;
            end
            if (rx_load && !ureset)
            begin
                o_status.receive_full_flag <= 1'b1;
                if (o_status.receive_full_flag && !rd_receive_holding_buffer)
                    o_status.overrun_flag <= 1'b1;
                if (rx_pe)
                    o_status.parity_fault_flag <= 1'b1;
                if (rx_fe)
                    o_status.framing_fault_flag <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_irq_on_rx;
        @(posedge i_clk_sys) disable iff (!i_reset_n) rx_load && !ureset |=> o_serial_irq_flag && o_status.receive_full_flag;
    endproperty
    a_irq_on_rx: assert property (p_irq_on_rx) else $error("frame end did not raise flags");
    property p_irq_on_tx;
        @(posedge i_clk_sys) disable iff (!i_reset_n) tx_load |=> o_serial_irq_flag && tx_state != SP_TX_IDLE;
    endproperty
    a_irq_on_tx: assert property (p_irq_on_tx) else $error("shifter load did not raise irq");
    property p_read_clears;
        @(posedge i_clk_sys) disable iff (!i_reset_n) rd_receive_holding_buffer && !rx_load && !ureset |=> !o_status.receive_full_flag;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("buffer read left full flag");
    property p_overrun;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
            rx_load && !ureset && o_status.receive_full_flag && !rd_receive_holding_buffer |=> o_status.overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_soft_reset;
        @(posedge i_clk_sys) disable iff (!i_reset_n) ureset |=> o_txd && o_sclk_oe_n && o_status.transmit_room_flag;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset outputs wrong");
    property p_sio_rest;
        @(posedge i_clk_sys) disable iff (!i_reset_n) is_sio && !gate_en ##1 is_sio |-> o_sclk;
    endproperty
    a_sio_rest: assert property (p_sio_rest) else $error("idle serial I/O clock not high");
    property p_tx_stops;
        @(posedge i_clk_sys) disable iff (!i_reset_n) tx_state == SP_TX_IDLE && !tx_en |=> tx_state == SP_TX_IDLE;
    endproperty
    a_tx_stops: assert property (p_tx_stops) else $error("transmit started while disabled");
    property p_timer_read;
        @(posedge i_clk_sys) disable iff (!i_reset_n) i_pf_rd && i_pf_addr == SP_ADDR_TIMER |=> o_pf_rdata == $past(count);
    endproperty
    a_timer_read: assert property (p_timer_read) else $error("timer read not live count");
    property p_err_clear;
        @(posedge i_clk_sys) disable iff (!i_reset_n) i_error_clear_bit && !rx_load |=> !o_status.framing_fault_flag;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error clear ignored");
endmodule // sp_serial_port
`default_nettype wire

// File: verif/sp_remote_model.sv
// Remote serial partner that returns the device's own output on the shared clock
`timescale 1ns/100ps
`default_nettype none
module sp_remote_model (
    input wire logic i_sclk,
    input wire logic i_txd,
    output logic o_rxd
);
    // Idle line is high; output moves only on clock rises, half a period after the
    // device's falls, so the copy never races the transmit change
    initial o_rxd = 1'b1;
    always @(posedge i_sclk) o_rxd <= i_txd;
endmodule // sp_remote_model
`default_nettype wire

// File: verif/test_serial_port_datapath.sv
// Self-checking bench for the serial port datapath
`timescale 1ns/100ps
`default_nettype none
module test_serial_port_datapath;
    import sp_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ctl_wr = 1'b0, ack = 1'b0;
    logic soft_rst = 1'b0, err_clr = 1'b0, irq_clr = 1'b0, rxd, sclk, sclk_oe_n, sclk_lvl, txd, irq;
    logic rxe_b = 1'b1, txe_b = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    sp_cfg_t cfg = '{SP_ASYNC, 2'h3, 1'b1, 1'b0, 1'b0, 1'b1};
    sp_status_t st;
    int err_total = 0, total_checks = 0;
    // Released clock pin is pulled high
    wire logic sclk_pin = sclk_oe_n ? 1'b1 : sclk;
    wire logic [6:0] flags = {irq, st};

    sp_serial_port uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_pf_addr(addr), .i_pf_wr(wr),
        .i_pf_rd(rd), .i_pf_wdata(wdata), .o_pf_rdata(rdata), .i_cfg(cfg), .i_ctl_wr(ctl_wr),
        .i_receive_enable_bit(rxe_b), .i_transmit_enable_bit(txe_b), .i_port_soft_reset(soft_rst),
        .i_error_clear_bit(err_clr), .i_serial_irq_clear(irq_clr), .i_irq_ack(ack), .i_rxd(rxd),
        .i_sclk(sclk_pin), .o_sclk(sclk), .o_sclk_oe_n(sclk_oe_n), .o_sclk_level(sclk_lvl),
        .o_txd(txd), .o_serial_irq_flag(irq), .o_status(st));
    // Transmit line reaches the partner directly, as with the shared port bit held high
    sp_remote_model partner (.i_sclk(sclk_pin), .i_txd(txd), .o_rxd(rxd));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // --------------------------------------------------
    // Access tasks
    // --------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = ~w;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    // One-cycle strobe: 0 control write, 1 irq clear, 2 error clear, 3 level-four entry
    task automatic pulse(input int k);
        @(negedge clk);
        ctl_wr = k == 0;
        irq_clr = k == 1;
        err_clr = k == 2;
        ack = k == 3;
        @(negedge clk);
        {ctl_wr, irq_clr, err_clr, ack} = 4'h0;
    endtask

    // Bounded wait for one flag bit; giving up counts as a mismatch
    task automatic wait_for(input int b);
        int n;
        n = 0;
        while (flags[b] !== 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, flags[b]}, 8'h01);
    endtask

    task automatic close_out();
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------
    // Tests
    // --------------------------------------------------
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        chk({1'b0, flags}, 8'h38);
        chk({7'h0, txd}, 8'h01);
        acc(1'b1, SP_ADDR_TIMER, 8'h01);
        acc(1'b0, SP_ADDR_TIMER, 8'h00);
        chk({7'h0, v <= 8'h01}, 8'h01);
        pulse(0);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk({1'b0, flags}, 8'h28);
        acc(1'b1, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'haa);
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'ha5);
        chk({1'b0, flags}, 8'h60);
        chk({7'h0, sclk_oe_n}, 8'h00);
        pulse(1);
        chk({1'b0, flags}, 8'h20);
        wait_for(4);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'ha5);
        chk({1'b0, flags & 7'h57}, 8'h40);
        acc(1'b0, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h00);
        chk(v, 8'h00);
        wait_for(3);
        cfg.len_code = 2'h0;
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'hff);
        wait_for(4);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'h1f);
        // Two characters back to back, first one left unread
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h11);
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h12);
        wait_for(4);
        wait_for(3);
        repeat (300) @(negedge clk);
        chk({7'h0, flags[1]}, 8'h01);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'h12);
        pulse(2);
        chk({7'h0, flags[1]}, 8'h00);
        pulse(3);
        chk({7'h0, flags[6]}, 8'h00);
        // Disabling the transmitter lets the frame in flight finish, then holds the queue
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h0b);
        txe_b = 1'b0;
        pulse(0);
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h0c);
        wait_for(4);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'h0b);
        repeat (1400)
        begin
            @(negedge clk);
            chk({7'h0, sclk_lvl}, {7'h0, sclk_pin});
        end
        chk({1'b0, flags & 7'h18}, 8'h00);
        txe_b = 1'b1;
        pulse(0);
        wait_for(4);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'h0c);
        wait_for(3);
        // Isosynchronous loopback: one clock per bit, clock shared with the partner
        cfg.mode = SP_ISO;
        cfg.len_code = 2'h3;
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h3c);
        wait_for(4);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'h3c);
        wait_for(3);
        // Serial I/O receive starts itself while enabled and drops its enable at the end
        cfg.mode = SP_SIO;
        wait_for(4);
        acc(1'b0, SP_ADDR_RECEIVE_HOLDING_BUFFER, 8'h00);
        chk(v, 8'hff);
        repeat (40)
        begin
            @(negedge clk);
            chk({4'h0, sclk, flags[4], 2'h0}, 8'h08);
        end
        acc(1'b1, SP_ADDR_TRANSMIT_HOLDING_BUFFER, 8'h0a);
        soft_rst = 1'b1;
        repeat (2) @(negedge clk);
        chk({1'b0, flags}, 8'h38);
        chk({6'h0, txd, sclk_oe_n}, 8'h03);
        close_out();
    end

    initial
    begin
        #200000;
        err_total++;
        close_out();
    end
endmodule // test_serial_port_datapath
`default_nettype wire
